// file: src/gss_fifo.sv
// Parameterised valid/ready FIFO for captured scan bits
`timescale 1ns/1ns
module gss_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rst_b,
  // Fill and drain sides
  gss_stream_if.snk            wr,
  gss_stream_if.src            rd,
  // Fill level
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = DEPTH[AW:0];

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign wr.ready = (count != FULL);
  assign rd.valid = (count != '0);
  assign rd.data  = mem[rd_ptr];
  assign push     = wr.valid & wr.ready;
  assign pop      = rd.valid & rd.ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_wr_ptr = wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
    if (!rst_b) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    wr_ptr <= next_wr_ptr;
    rd_ptr <= next_rd_ptr;
    count  <= next_count;
    if (push) begin
      mem[wr_ptr] <= wr.data;
    end
  end

  a_fifo_bound: assert property (@(posedge sys_clk) disable iff (!rst_b)
    count <= FULL && (count != FULL || !wr.ready))
    else $error("fifo count out of range");
endmodule

// file: src/gss_pkg.sv
// Shared constants and types for the gate scan shift register
package gss_pkg;

  // ==========================================================
  // Chain geometry
  localparam int STAGES     = 240;
  localparam int GROUPS     = 3;
  localparam int WORDS      = 8;
  localparam int WSEL_W     = 3;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 1;

  // ==========================================================
  // Synchroniser bit positions
  localparam int SYNC_BITS = 8;
  localparam int SY_CLK    = 0;
  localparam int SY_LOW    = 1;
  localparam int SY_HIGH   = 2;
  localparam int SY_DIR    = 3;
  localparam int SY_BLANK  = 4;
  localparam int SY_TEST   = 7;

  // ==========================================================
  // Register map (byte addresses)
  localparam int          ADDR_W     = 5;
  localparam logic [4:0]  REG_CTRL   = 5'h00;
  localparam logic [4:0]  REG_STATUS = 5'h04;
  localparam logic [4:0]  REG_COUNT  = 5'h08;
  localparam logic [4:0]  REG_WSEL   = 5'h0c;
  localparam logic [4:0]  REG_WDATA  = 5'h10;

  // Field positions
  localparam int CTRL_HOLD = 0;
  localparam int ST_DIR    = 0;
  localparam int ST_EMPTY  = 1;
  localparam int ST_OVF    = 2;
  localparam int ST_TEST   = 3;
  localparam int ST_CASC   = 4;

  // Reset values
  localparam logic        HOLD_RST  = 1'b0;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [2:0]  WSEL_RST  = 3'h0;

  // ==========================================================
  // Bus answer states
  typedef enum logic [0:0] {
    GSS_BUS_IDLE = 1'b0,
    GSS_BUS_ACK  = 1'b1
  } gss_bus_state_t;

endpackage

// file: src/gss_stream_if.sv
// Valid/ready stream carrier between the block's own modules
`timescale 1ns/1ns
interface gss_stream_if #(parameter int WIDTH = 1) ();
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: src/gss_sync.sv
// Two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/1ns
module gss_sync #(
  parameter int N = 1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  // Pins in, synchronised levels out
  input  wire logic [N-1:0] async_in,
  output logic      [N-1:0] sync_out
);
  logic [N-1:0] stage1;
  logic [N-1:0] next_stage1;
  logic [N-1:0] next_sync_out;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      always_comb begin
        next_stage1[i]   = rst_b ? async_in[i] : 1'b0;
        next_sync_out[i] = rst_b ? stage1[i] : 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    stage1   <= next_stage1;
    sync_out <= next_sync_out;
  end
endmodule

// file: src/gss_top.sv
// Bidirectional 240-stage gate scan shift register with register port
`timescale 1ns/1ns
module gss_top (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst_b,
  // Avalon-MM register slave
  input  wire logic [gss_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  // Scan control pins
  input  wire logic                        scan_shift_clock,
  input  wire logic                        scan_dir_up,
  input  wire logic                        group_a_blank_n,
  input  wire logic                        group_b_blank_n,
  input  wire logic                        group_c_blank_n,
  input  wire logic                        factory_check_pin,
  // Two-way serial end pins
  input  wire logic                        low_end_serial_pin_in,
  output logic                             low_end_serial_pin_out,
  output logic                             low_end_serial_pin_oe,
  input  wire logic                        high_end_serial_pin_in,
  output logic                             high_end_serial_pin_out,
  output logic                             high_end_serial_pin_oe,
  // Gate line drive
  output logic      [gss_pkg::STAGES-1:0]  gate_line_outputs
);
  import gss_pkg::*;

  // ==========================================================
  // Pin synchronisation and edge detection
  logic [SYNC_BITS-1:0] pins_s;
  logic                 clk_prev;
  logic                 next_clk_prev;
  logic                 rise_evt;
  logic                 fall_evt;
  logic                 dir_up;
  logic [GROUPS-1:0]    blank_act;

  gss_sync #(.N(SYNC_BITS)) u_sync (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .async_in ({factory_check_pin, group_c_blank_n, group_b_blank_n,
                group_a_blank_n, scan_dir_up, high_end_serial_pin_in,
                low_end_serial_pin_in, scan_shift_clock}),
    .sync_out (pins_s)
  );

  assign next_clk_prev = rst_b ? pins_s[SY_CLK] : 1'b0;
  assign rise_evt  = pins_s[SY_CLK] & ~clk_prev;
  assign fall_evt  = ~pins_s[SY_CLK] & clk_prev;
  assign dir_up    = pins_s[SY_DIR];
  assign blank_act = pins_s[SY_BLANK +: GROUPS];

  always_ff @(posedge sys_clk) begin
    clk_prev <= next_clk_prev;
  end

  // ==========================================================
  // Capture FIFO between the input pin and the chain
  gss_stream_if #(.WIDTH(FIFO_WIDTH)) cap_if ();
  gss_stream_if #(.WIDTH(FIFO_WIDTH)) chn_if ();
  logic [$clog2(FIFO_DEPTH):0] fifo_count;
  logic                        hold;
  logic                        pop;

  // Input end follows the direction select
  assign cap_if.valid = rise_evt;
  assign cap_if.data  = dir_up ? pins_s[SY_LOW]
                               : pins_s[SY_HIGH];
  assign chn_if.ready = ~hold;
  assign pop          = chn_if.valid & chn_if.ready;

  gss_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .wr      (cap_if),
    .rd      (chn_if),
    .count   (fifo_count)
  );

  // ==========================================================
  // Shift chain, cascade output and gate drive
  logic [STAGES-1:0] chain;
  logic [STAGES-1:0] next_chain;
  logic [STAGES-1:0] show_mask;
  logic [STAGES-1:0] next_gate;
  logic              cascade_q;
  logic              next_cascade_q;
  logic [15:0]       shift_count;
  logic [15:0]       next_shift_count;

  genvar gi;
  generate
    for (gi = 0; gi < STAGES; gi++) begin : g_mask
      assign show_mask[gi] = ~blank_act[gi % GROUPS];
    end
  endgenerate

  always_comb begin
    next_chain       = chain;
    next_cascade_q   = cascade_q;
    next_shift_count = shift_count;
    if (pop) begin
      // One synchronous move of all stages
      if (dir_up) begin
        next_chain = {chain[STAGES-2:0], chn_if.data[0]};
      end else begin
        next_chain = {chn_if.data[0], chain[STAGES-1:1]};
      end
      next_shift_count = shift_count + 16'h0001;
    end
    if (fall_evt) begin
      next_cascade_q = dir_up ? chain[STAGES-1] : chain[0];
    end
    next_gate = chain & show_mask;
    if (!rst_b) begin
      // Cleared only for a clean start; content still needs 240 shifts
      next_chain       = '0;
      next_cascade_q   = 1'b0;
      next_shift_count = COUNT_RST;
      next_gate        = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    chain             <= next_chain;
    cascade_q         <= next_cascade_q;
    shift_count       <= next_shift_count;
    gate_line_outputs <= next_gate;
  end

  // Only the output end drives; the other end listens
  assign high_end_serial_pin_out = cascade_q;
  assign low_end_serial_pin_out  = cascade_q;
  assign high_end_serial_pin_oe  = dir_up;
  assign low_end_serial_pin_oe   = ~dir_up;

  // ==========================================================
  // Avalon-MM register slave, one wait state per access
  gss_bus_state_t bus_state;
  gss_bus_state_t next_bus_state;
  logic [31:0]    next_readdata;
  logic           next_hold;
  logic           ovf;
  logic           next_ovf;
  logic [2:0]     wsel;
  logic [2:0]     next_wsel;
  logic           req;
  logic           wr_go;
  logic [255:0]   chain_pad;
  logic [31:0]    status_word;

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & (bus_state == GSS_BUS_IDLE);
  assign wr_go  = avs_write & (bus_state == GSS_BUS_ACK) & avs_byteenable[0];
  assign chain_pad = {16'h0000, chain};
  assign status_word = {27'h0000000, cascade_q, pins_s[SY_TEST],
                        ovf, ~chn_if.valid, dir_up};

  always_comb begin
    next_bus_state = bus_state;
    next_readdata  = avs_readdata;
    next_hold      = hold;
    next_ovf       = ovf;
    next_wsel      = wsel;
    case (bus_state)
      GSS_BUS_IDLE: begin
        if (req) begin
          next_bus_state = GSS_BUS_ACK;
          next_readdata  = 32'h00000000;
          if (avs_read) begin
            case (avs_address)
              REG_CTRL:   next_readdata[CTRL_HOLD] = hold;
              REG_STATUS: next_readdata = status_word;
              REG_COUNT:  next_readdata = {16'h0000, shift_count};
              REG_WSEL:   next_readdata = {29'h00000000, wsel};
              REG_WDATA:  next_readdata = chain_pad[{wsel, 5'h00} +: 32];
              default:    next_readdata = 32'h00000000;
            endcase
          end
        end
      end
      GSS_BUS_ACK: begin
        next_bus_state = GSS_BUS_IDLE;
      end
      default: next_bus_state = GSS_BUS_IDLE;
    endcase
    if (wr_go && avs_address == REG_CTRL) begin
      next_hold = avs_writedata[CTRL_HOLD];
    end
    if (wr_go && avs_address == REG_WSEL) begin
      next_wsel = avs_writedata[2:0];
    end
    if (wr_go && avs_address == REG_STATUS && avs_writedata[ST_OVF]) begin
      next_ovf = 1'b0;
    end
    // A dropped capture beats a clear in the same cycle
    if (cap_if.valid && !cap_if.ready) begin
      next_ovf = 1'b1;
    end
    if (!rst_b) begin
      next_bus_state = GSS_BUS_IDLE;
      next_readdata  = 32'h00000000;
      next_hold      = HOLD_RST;
      next_ovf       = 1'b0;
      next_wsel      = WSEL_RST;
    end
  end

  always_ff @(posedge sys_clk) begin
    bus_state    <= next_bus_state;
    avs_readdata <= next_readdata;
    hold         <= next_hold;
    ovf          <= next_ovf;
    wsel         <= next_wsel;
  end

  // ==========================================================
  // Checks
  a_shift_up: assert property (@(posedge sys_clk) disable iff (!rst_b)
    pop && dir_up |=> chain[STAGES-1:1] == $past(chain[STAGES-2:0])
                      && chain[0] == $past(chn_if.data[0]))
    else $error("upward shift wrong");

  a_shift_down: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    pop && !dir_up |=> chain[STAGES-2:0] == $past(chain[STAGES-1:1])
                       && chain[STAGES-1] == $past(chn_if.data[0]))
    else $error("downward shift wrong");

  a_chain_still: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    !pop |=> $stable(chain))
    else $error("chain moved without a shift");

  a_capture_low: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    rise_evt && dir_up && !hold && fifo_count == '0 && !$past(dir_up) == 1'b0
    |-> ##2 chain[0] == $past(pins_s[SY_LOW], 2))
    else $error("low end bit not captured into stage one");

  a_cascade_out: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    fall_evt |=> high_end_serial_pin_out ==
      ($past(dir_up) ? $past(chain[STAGES-1]) : $past(chain[0])))
    else $error("cascade bit wrong after falling edge");

  a_end_dir: assert property (@(posedge sys_clk) disable iff (!rst_b)
    high_end_serial_pin_oe == dir_up && low_end_serial_pin_oe == !dir_up
    && low_end_serial_pin_out == cascade_q)
    else $error("end pin direction wrong");

  a_blank_group: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    blank_act[0] |=> gate_line_outputs[0] == 1'b0
      && gate_line_outputs[3] == 1'b0 && gate_line_outputs[237] == 1'b0)
    else $error("group a not blanked");

  a_gate_follow: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    !blank_act[2] ##1 !$past(blank_act[2]) |->
      gate_line_outputs[239] == $past(chain[239])
      && gate_line_outputs[2] == $past(chain[2]))
    else $error("gate output does not follow its stage");

  a_bus_wait: assert property (@(posedge sys_clk) disable iff (!rst_b)
    req && bus_state == GSS_BUS_IDLE |=> bus_state == GSS_BUS_ACK
      && !avs_waitrequest)
    else $error("bus answer not one wait state");

  a_capture_high: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    rise_evt && !dir_up && !hold && fifo_count == '0 && !$past(dir_up)
    |-> ##2 chain[STAGES-1] == $past(pins_s[SY_HIGH], 2))
    else $error("high end bit not captured into last stage");

  a_blank_group_b: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    blank_act[1] |=> gate_line_outputs[1] == 1'b0
      && gate_line_outputs[4] == 1'b0 && gate_line_outputs[238] == 1'b0)
    else $error("group b not blanked");

  a_count_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
    pop |=> shift_count == $past(shift_count) + 16'h0001)
    else $error("shift count did not step");

  a_ovf_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cap_if.valid && !cap_if.ready |=> ovf)
    else $error("dropped capture not flagged");

  a_hold_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_go && avs_address == REG_CTRL
    |=> hold == $past(avs_writedata[CTRL_HOLD]))
    else $error("hold bit write lost");
endmodule

// file: tb/gss_ctrl_model.sv
// Panel timing controller model driving the scan control pins
`timescale 1ns/1ns
module gss_ctrl_model (
  // Clock
  input  wire logic sys_clk,
  // Scan control pins
  output logic      scan_shift_clock,
  output logic      scan_dir_up,
  output logic      group_a_blank_n,
  output logic      group_b_blank_n,
  output logic      group_c_blank_n,
  output logic      factory_check_pin,
  // Serial data for whichever end listens
  output logic      serial_drv
);
  initial begin
    scan_shift_clock  = 1'b0;
    scan_dir_up       = 1'b1;
    group_a_blank_n   = 1'b0;
    group_b_blank_n   = 1'b0;
    group_c_blank_n   = 1'b0;
    factory_check_pin = 1'b0;
    serial_drv        = 1'b0;
  end
  // ==========================================================
  // Control tasks
  // Only called while the device is held in reset
  task automatic set_dir(input logic d);
    @(posedge sys_clk) scan_dir_up <= d;
  endtask
  task automatic set_blank(input logic [2:0] b);
    @(posedge sys_clk) {group_a_blank_n, group_b_blank_n,
                        group_c_blank_n} <= b;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One bit per pulse; clock idles low between pulses
  task automatic shift_bit(input logic b);
    @(posedge sys_clk) serial_drv <= b;
    wait_clk(5);
    scan_shift_clock <= 1'b1;
    wait_clk(5);
    // Hold time over: line no longer shows the bit
    serial_drv <= ~b;
    wait_clk(5);
    scan_shift_clock <= 1'b0;
    wait_clk(6);
  endtask
endmodule

// file: tb/tb.sv
// Self-checking bench for the gate scan shift register
`timescale 1ns/1ns
module tb;
  import gss_pkg::*;
  logic              sys_clk = 1'b0;
  logic              rst_b = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [31:0]       avs_writedata = '0;
  logic [3:0]        avs_byteenable = 4'hf;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              clk_s, dir, ba, bb, bc, tst, drv;
  logic              lo_out, lo_oe, hi_out, hi_oe;
  logic [STAGES-1:0] gates;
  logic [STAGES-1:0] exp_g = '0;
  logic              casc = 1'b0;
  logic [31:0]       rd;
  int                errors = 0;
  int                tests_run = 0;
  int                cyc = 0;
  int                n = 0;
  wire               lo_w = lo_oe ? lo_out : drv;
  wire               hi_w = hi_oe ? hi_out : drv;

  always #5 sys_clk = ~sys_clk;

  gss_top u_gss_top (
    .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .scan_shift_clock(clk_s), .scan_dir_up(dir),
    .group_a_blank_n(ba), .group_b_blank_n(bb), .group_c_blank_n(bc),
    .factory_check_pin(tst), .low_end_serial_pin_in(lo_w),
    .low_end_serial_pin_out(lo_out), .low_end_serial_pin_oe(lo_oe),
    .high_end_serial_pin_in(hi_w), .high_end_serial_pin_out(hi_out),
    .high_end_serial_pin_oe(hi_oe), .gate_line_outputs(gates));

  gss_ctrl_model u_gss_ctrl_model (
    .sys_clk(sys_clk), .scan_shift_clock(clk_s), .scan_dir_up(dir),
    .group_a_blank_n(ba), .group_b_blank_n(bb), .group_c_blank_n(bc),
    .factory_check_pin(tst), .serial_drv(drv));

  // ==========================================================
  // Helpers
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [255:0] e,
                     input logic [255:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Avalon-MM access; rd holds read data
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    int t;
    t = 0;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_read      <= ~w;
    avs_write     <= w;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
      t++;
    end while (avs_waitrequest !== 1'b0);
    chk("bus cycles", 2, t);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  function automatic logic pb(input int k);
    return k[0] ^ k[2] ^ k[5];
  endfunction

  function automatic logic [STAGES-1:0] gm(input int g);
    for (int i = 0; i < STAGES; i++)
      gm[i] = (i % 3 == g);
  endfunction

  // Checks only once every stage has been overwritten
  task automatic shift(input logic b, input logic upd);
    u_gss_ctrl_model.shift_bit(b);
    if (upd) begin
      exp_g = dir ? {exp_g[STAGES-2:0], b} : {b, exp_g[STAGES-1:1]};
      casc = dir ? exp_g[STAGES-1] : exp_g[0];
      n++;
      if (n >= STAGES) begin
        chk("gates", exp_g, gates);
        chk("cascade", casc, dir ? hi_w : lo_w);
      end
    end
  endtask

  task automatic do_reset(input logic d);
    rst_b <= 1'b0;
    u_gss_ctrl_model.set_dir(d);
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    n = 0;
    repeat (4) @(posedge sys_clk);
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end

  // ==========================================================
  // Tests
  initial begin
    do_reset(1'b1);
    chk("oe up", 2'b10, {hi_oe, lo_oe});
    for (int i = 0; i < STAGES + 1; i++)
      shift(pb(i), 1'b1);
    for (int g = 0; g < 4; g++) begin
      u_gss_ctrl_model.set_blank(g < 3 ? 3'h4 >> g : 3'h7);
      u_gss_ctrl_model.wait_clk(8);
      chk("blank", exp_g & (g < 3 ? ~gm(g) : '0), gates);
    end
    u_gss_ctrl_model.set_blank(3'h0);
    u_gss_ctrl_model.wait_clk(8);
    chk("unblank", exp_g, gates);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("status", {casc, 4'h3}, rd);
    bus(1'b0, REG_COUNT, 32'h0);
    chk("count", n[15:0], rd);
    for (int w = 0; w < WORDS; w++) begin
      bus(1'b1, REG_WSEL, w);
      bus(1'b0, REG_WDATA, 32'h0);
      chk("wdata", 32'({16'h0, exp_g} >> (32 * w)), rd);
    end
    bus(1'b0, 5'h14, 32'h0);
    chk("unmapped", 32'h0, rd);
    avs_byteenable <= 4'he;
    bus(1'b1, REG_WSEL, 32'h2);
    avs_byteenable <= 4'hf;
    bus(1'b0, REG_WSEL, 32'h0);
    chk("wsel masked", 32'h7, rd);
    do_reset(1'b0);
    chk("oe down", 2'b01, {hi_oe, lo_oe});
    for (int i = 0; i < STAGES + 8; i++)
      shift(pb(i + 3), 1'b1);
    // Freeze: fill the buffer past its depth
    bus(1'b1, REG_CTRL, 32'h1);
    bus(1'b0, REG_CTRL, 32'h0);
    chk("hold", 32'h1, rd);
    for (int i = 0; i < FIFO_DEPTH + 1; i++)
      shift(pb(i), 1'b0);
    chk("gates held", exp_g, gates);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("status full", {casc, 4'h4}, rd);
    bus(1'b1, REG_STATUS, 32'h4);
    bus(1'b1, REG_CTRL, 32'h0);
    u_gss_ctrl_model.wait_clk(40);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      exp_g = {pb(i), exp_g[STAGES-1:1]};
      n++;
    end
    chk("gates drained", exp_g, gates);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("status empty", {casc, 4'h2}, rd);
    bus(1'b0, REG_COUNT, 32'h0);
    chk("count", n[15:0], rd);
    end_of_test();
  end
endmodule
